//--- hw/timer_buffer_output_irq.sv
// buffered general registers, output control, status flags and interrupts of the timer
// Notes on behaviour
// - only channels three and four own shadow registers
// - buffered compare register reloads from its shadow on its own match
// - buffered capture: counter into general register, old value into shadow
// - complementary mode reloads at primary A match (up) and secondary underflow
// - reset-synchronized mode reloads at primary A match
// - compare reload happens in the same cycle the pin toggles, in normal mode
// - clearing a master enable hands the pin back to port logic
// - PWM modes, trigger control 0: channel one capture A clears enables
// - PWM modes invert pin levels through the two level select bits
// - match asserted when counter advances from the matching count
// - capture sets its flag and loads counter into general register together
// - wrap flag sets on up wrap past all ones or down past zero
// - flag clears only after reading it as one then writing zero
// - five channels by three sources give fifteen request lines
// - request raised only while flag and enable are both one
// - channel zero first by default; A, B, wrap within channel; reorderable
// - complementary mode: primary A flag only up, secondary wrap only underflow
`timescale 1ns/100ps
`default_nettype none
`include "timer_defs.svh"

module timer_buffer_output_irq
  import timer_pkg::*;
(
  input  wire logic                         i_clk,
  input  wire logic                         i_rstn,
  input  wire apb_req_t                     i_apb,
  output logic [`TMR_DW-1:0]                o_prdata,
  output logic                              o_pready,
  output logic                              o_pslverr,
  input  wire chan_in_t [`TMR_NCH-1:0]      i_chan,
  output logic [`TMR_NPIN-1:0]              o_pin_level,
  output logic [`TMR_NPIN-1:0]              o_pin_timer_en,
  output logic [`TMR_NSRC-1:0]              o_irq_src,
  output logic                              o_irq,
  output logic [3:0]                        o_irq_top
);

  localparam state_t ST_RST = '{oe: `TMR_OE_RST, default: '0};

  state_t                    st;
  state_t                    next_st;
  chan_ev_t [`TMR_NCH-1:0]   ev;
  logic                      setup;
  logic                      acc;
  logic                      pwm;
  logic                      comp;
  logic                      xfer_pwm;
  logic [`TMR_DW:0]          rd;
  logic [`TMR_NSRC-1:0]      clr;
  logic [`TMR_NSRC-1:0]      set;
  logic [`TMR_NSRC-1:0]      req;
  logic [`TMR_NCH-1:0]       cap_a_ev;
  logic [`TMR_NCH-1:0]       cap_b_ev;

  function automatic logic [`TMR_AW-1:0] gr_addr(input int ch, input logic b);
    return `TMR_AW'(`TMR_OFS_GR_BASE + ch * `TMR_GR_STRIDE + (b ? `TMR_OFS_GRB : 8'h00));
  endfunction

  function automatic logic [`TMR_AW-1:0] sh_addr(input int k, input logic b);
    return `TMR_AW'(`TMR_OFS_SH_BASE + (k * 2 + int'(b)) * `TMR_SH_STRIDE);
  endfunction

  function automatic int src_idx(input int ch, input int s);
    return ch * `TMR_SRC_PER_CH + s;
  endfunction

  // bit above the data says the address is mapped
  function automatic logic [`TMR_DW:0] rd_mux(input state_t s, input logic [`TMR_AW-1:0] a);
    logic [`TMR_DW:0] r;
    r = '0;
    unique case (a)
      `TMR_OFS_CTRL:   r = {1'b1, `TMR_DW'(s.ctrl)};
      `TMR_OFS_CAPSEL: r = {1'b1, `TMR_DW'({s.cap_b, s.cap_a})};
      `TMR_OFS_OUTEN:  r = {1'b1, `TMR_DW'(s.oe)};
      `TMR_OFS_STATUS: r = {1'b1, `TMR_DW'(s.flags)};
      `TMR_OFS_IEN:    r = {1'b1, `TMR_DW'(s.ien)};
      `TMR_OFS_PRIO1:  r = {1'b1, `TMR_DW'(s.prio[`TMR_PRIO1_W-1:0])};
      `TMR_OFS_PRIO2:  r = {1'b1, `TMR_DW'(s.prio[`TMR_NCH-1:`TMR_PRIO1_W])};
      default: begin
        for (int ch = 0; ch < `TMR_NCH; ch++) begin
          if (a == gr_addr(ch, 1'b0)) r = {1'b1, `TMR_DW'(s.general_reg_a[ch])};
          if (a == gr_addr(ch, 1'b1)) r = {1'b1, `TMR_DW'(s.general_reg_b[ch])};
        end
        // a shadow read is side-effect free
        for (int k = 0; k < `TMR_NBUF; k++) begin
          if (a == sh_addr(k, 1'b0)) r = {1'b1, `TMR_DW'(s.sha[k])};
          if (a == sh_addr(k, 1'b1)) r = {1'b1, `TMR_DW'(s.shb[k])};
        end
      end
    endcase
    return r;
  endfunction

  // priority channels first, then the rest; channel order, then A, B, wrap
  function automatic logic [3:0] pick(input logic [`TMR_NSRC-1:0] r,
                                      input logic [`TMR_NCH-1:0]  p);
    logic [3:0] top;
    logic       found;
    top   = '0;
    found = 1'b0;
    for (int pass = 0; pass < 2; pass++) begin
      for (int ch = 0; ch < `TMR_NCH; ch++) begin
        for (int s = 0; s < `TMR_SRC_PER_CH; s++) begin
          if (!found && r[src_idx(ch, s)] && (p[ch] == (pass == 0))) begin
            top   = 4'(src_idx(ch, s));
            found = 1'b1;
          end
        end
      end
    end
    return top;
  endfunction

  for (genvar g = 0; g < `TMR_NCH; g++) begin : g_ch
    timer_chan_event u_ev (
      .i_chan      (i_chan[g]),
      .i_gra       (st.general_reg_a[g]),
      .i_grb       (st.general_reg_b[g]),
      .i_cap_sel_a (st.cap_a[g]),
      .i_cap_sel_b (st.cap_b[g]),
      .o_ev        (ev[g])
    );
  end

  always_comb begin
    next_st  = st;
    setup    = i_apb.psel && !i_apb.penable;
    acc      = i_apb.psel && i_apb.penable;
    pwm      = (st.ctrl.mode == MODE_RSYNC) || (st.ctrl.mode == MODE_COMP);
    comp     = (st.ctrl.mode == MODE_COMP);
    rd       = rd_mux(st, i_apb.paddr);
    clr      = '0;
    set      = '0;
    cap_a_ev = '0;
    cap_b_ev = '0;
    xfer_pwm = 1'b0;

    // read data is latched in the setup cycle so prdata comes from a flop
    if (setup) begin
      next_st.rdata = rd[`TMR_DW-1:0];
    end

    // a flag read as one becomes clearable
    if (acc && !i_apb.pwrite && (i_apb.paddr == `TMR_OFS_STATUS)) begin
      next_st.armed = st.armed | (st.rdata[`TMR_NSRC-1:0] & st.flags);
    end

    if (acc && i_apb.pwrite && rd[`TMR_DW]) begin
      case (i_apb.paddr)
        `TMR_OFS_CTRL:   next_st.ctrl = ctrl_t'(i_apb.pwdata[$bits(ctrl_t)-1:0]);
        `TMR_OFS_CAPSEL: {next_st.cap_b, next_st.cap_a} = i_apb.pwdata[2*`TMR_NCH-1:0];
        `TMR_OFS_OUTEN:  next_st.oe = i_apb.pwdata[`TMR_NPIN-1:0];
        `TMR_OFS_STATUS: clr = st.armed & ~i_apb.pwdata[`TMR_NSRC-1:0];
        `TMR_OFS_IEN:    next_st.ien = i_apb.pwdata[`TMR_NSRC-1:0];
        `TMR_OFS_PRIO1:  next_st.prio[`TMR_PRIO1_W-1:0] = i_apb.pwdata[`TMR_PRIO1_W-1:0];
        `TMR_OFS_PRIO2: begin
          next_st.prio[`TMR_NCH-1:`TMR_PRIO1_W] = i_apb.pwdata[`TMR_NCH-`TMR_PRIO1_W-1:0];
        end
        default: begin
          for (int ch = 0; ch < `TMR_NCH; ch++) begin
            if (i_apb.paddr == gr_addr(ch, 1'b0)) next_st.general_reg_a[ch] = i_apb.pwdata[`TMR_CW-1:0];
            if (i_apb.paddr == gr_addr(ch, 1'b1)) next_st.general_reg_b[ch] = i_apb.pwdata[`TMR_CW-1:0];
          end
          for (int k = 0; k < `TMR_NBUF; k++) begin
            if (i_apb.paddr == sh_addr(k, 1'b0)) next_st.sha[k] = i_apb.pwdata[`TMR_CW-1:0];
            if (i_apb.paddr == sh_addr(k, 1'b1)) next_st.shb[k] = i_apb.pwdata[`TMR_CW-1:0];
          end
        end
      endcase
    end
    next_st.armed = next_st.armed & ~clr;

    // buffers transfer at primary A match (only going up in complementary mode) and, in complementary mode, at secondary underflow
    xfer_pwm = ((st.ctrl.mode == MODE_RSYNC) && ev[`TMR_PERIOD_CH].match_a) ||
               (comp && ((ev[`TMR_PERIOD_CH].match_a && !i_chan[`TMR_PERIOD_CH].down) ||
                         ev[`TMR_UNDER_CH].wrap_down));

    // capture wins over a register write landing in the same cycle
    for (int ch = 0; ch < `TMR_NCH; ch++) begin
      cap_a_ev[ch] = i_chan[ch].cap_a && st.cap_a[ch];
      cap_b_ev[ch] = i_chan[ch].cap_b && st.cap_b[ch];
      if (cap_a_ev[ch]) next_st.general_reg_a[ch] = i_chan[ch].cnt;
      if (cap_b_ev[ch]) next_st.general_reg_b[ch] = i_chan[ch].cnt;
      set[src_idx(ch, `TMR_SRC_A)] = cap_a_ev[ch] || (ev[ch].match_a &&
          !(comp && (ch == `TMR_PERIOD_CH) && i_chan[ch].down));
      set[src_idx(ch, `TMR_SRC_B)] = cap_b_ev[ch] || ev[ch].match_b;
      set[src_idx(ch, `TMR_SRC_W)] = (comp && (ch == `TMR_UNDER_CH)) ? ev[ch].wrap_down :
                                     (ev[ch].wrap_up || ev[ch].wrap_down);
    end

    // only the two PWM-capable channels carry shadows
    for (int k = 0; k < `TMR_NBUF; k++) begin
      if (st.ctrl.buf_en[k*2]) begin
        if (cap_a_ev[k+`TMR_BUF_CH0]) begin
          next_st.sha[k] = st.general_reg_a[k+`TMR_BUF_CH0];
        end else if (pwm ? xfer_pwm : ev[k+`TMR_BUF_CH0].match_a) begin
          next_st.general_reg_a[k+`TMR_BUF_CH0] = st.sha[k];
        end
      end
      if (st.ctrl.buf_en[k*2+1]) begin
        if (cap_b_ev[k+`TMR_BUF_CH0]) begin
          next_st.shb[k] = st.general_reg_b[k+`TMR_BUF_CH0];
        end else if (pwm ? xfer_pwm : ev[k+`TMR_BUF_CH0].match_b) begin
          next_st.general_reg_b[k+`TMR_BUF_CH0] = st.shb[k];
        end
      end
      // in normal mode the pin toggles on the same match that reloads the register
      next_st.pin[k*2]   = st.pin[k*2] ^ ev[k+`TMR_BUF_CH0].match_a;
      next_st.pin[k*2+1] = st.pin[k*2+1] ^ ev[k+`TMR_BUF_CH0].match_b;
    end

    // set wins over a clear in the same cycle
    next_st.flags = (st.flags & ~clr) | set;

    // the trigger overrides any enable write in the same cycle
    if (pwm && !st.ctrl.ext_trigger_disable_ctl && cap_a_ev[`TMR_TRIG_CH]) begin
      next_st.oe = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign o_pready  = acc;
  assign o_prdata  = st.rdata;
  assign o_pslverr = acc && !rd[`TMR_DW];

  // level select 1 keeps the pin active high; 0 inverts in both PWM modes
  assign o_pin_level = st.pin ^ (pwm ? ~{st.ctrl.level_select_secondary, st.ctrl.level_select_secondary, st.ctrl.level_select_primary, st.ctrl.level_select_primary}
                                      : {`TMR_NPIN{1'b0}});
  // a disabled pin is owned by the port data and direction logic
  assign o_pin_timer_en = st.oe;

  assign req       = st.flags & st.ien;
  assign o_irq_src = req;
  assign o_irq     = |req;
  assign o_irq_top = pick(req, st.prio);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_cap_a4_buf;
    (st.ctrl.mode == MODE_NORMAL) && st.cap_a[`TMR_UNDER_CH] && st.ctrl.buf_en[2] &&
    i_chan[`TMR_UNDER_CH].cap_a;
  endsequence

  sequence s_cmp_a3_buf;
    (st.ctrl.mode == MODE_NORMAL) && st.ctrl.buf_en[0] && ev[`TMR_PERIOD_CH].match_a;
  endsequence

  a_cap_shift: assert property (
    s_cap_a4_buf |=> (st.sha[1] == $past(st.general_reg_a[`TMR_UNDER_CH])) &&
                     (st.general_reg_a[`TMR_UNDER_CH] == $past(i_chan[`TMR_UNDER_CH].cnt)))
    else $error("capture did not shift general register into shadow");

  a_cap_flag_load: assert property (
    (i_chan[`TMR_TRIG_CH].cap_a && st.cap_a[`TMR_TRIG_CH]) |=>
      st.flags[src_idx(`TMR_TRIG_CH, `TMR_SRC_A)] &&
      (st.general_reg_a[`TMR_TRIG_CH] == $past(i_chan[`TMR_TRIG_CH].cnt)))
    else $error("capture flag or counter load missing");

  a_cmp_reload: assert property (
    s_cmp_a3_buf |=> st.general_reg_a[`TMR_PERIOD_CH] == $past(st.sha[0]))
    else $error("compare match did not reload from shadow");

  a_pin_same_cycle: assert property (
    s_cmp_a3_buf |=> (st.pin[0] != $past(st.pin[0])) &&
                     (st.general_reg_a[`TMR_PERIOD_CH] == $past(st.sha[0])))
    else $error("pin toggle and reload not together");

  a_rsync_reload: assert property (
    ((st.ctrl.mode == MODE_RSYNC) && st.ctrl.buf_en[1] && ev[`TMR_PERIOD_CH].match_a &&
     !st.cap_b[`TMR_PERIOD_CH]) |=> st.general_reg_b[`TMR_PERIOD_CH] == $past(st.shb[0]))
    else $error("reset-synchronized reload missing");

  a_comp_reload: assert property (
    ((st.ctrl.mode == MODE_COMP) && st.ctrl.buf_en[3] && ev[`TMR_UNDER_CH].wrap_down &&
     !st.cap_b[`TMR_UNDER_CH]) |=> st.general_reg_b[`TMR_UNDER_CH] == $past(st.shb[1]))
    else $error("complementary reload at underflow missing");

  a_ext_trigger_off: assert property (
    (pwm && !st.ctrl.ext_trigger_disable_ctl && st.cap_a[`TMR_TRIG_CH] && i_chan[`TMR_TRIG_CH].cap_a) |=>
      o_pin_timer_en == '0)
    else $error("external trigger did not clear enables");

  a_clear_after_read: assert property (
    $fell(st.flags[`TMR_SRC_W]) |-> $past(st.armed[`TMR_SRC_W]))
    else $error("flag cleared without prior read");

  a_wrap_sets_flag: assert property (
    ev[0].wrap_up |=> st.flags[`TMR_SRC_W])
    else $error("wrap flag not set");

  a_comp_down_no_flag: assert property (
    ((st.ctrl.mode == MODE_COMP) && i_chan[`TMR_PERIOD_CH].down &&
     !st.cap_a[`TMR_PERIOD_CH] && !st.flags[src_idx(`TMR_PERIOD_CH, `TMR_SRC_A)]) |=>
      !st.flags[src_idx(`TMR_PERIOD_CH, `TMR_SRC_A)])
    else $error("primary A flag set while counting down");

  a_irq_gated: assert property (
    (st.ien == '0) |-> ##1 (!o_irq || $past(st.ien) != st.ien))
    else $error("interrupt raised with all enables off");

  a_down_wrap_flag: assert property (
    ev[`TMR_TRIG_CH].wrap_down |=> st.flags[src_idx(`TMR_TRIG_CH, `TMR_SRC_W)])
    else $error("wrap flag not set on underflow");

  a_no_tick_no_match: assert property (
    (!i_chan[`TMR_PERIOD_CH].tick && !i_chan[`TMR_PERIOD_CH].cap_a &&
     !st.flags[src_idx(`TMR_PERIOD_CH, `TMR_SRC_A)]) |=>
      !st.flags[src_idx(`TMR_PERIOD_CH, `TMR_SRC_A)])
    else $error("match flag set without a counter advance");

  a_comp_under_b3: assert property (
    ((st.ctrl.mode == MODE_COMP) && st.ctrl.buf_en[1] && ev[`TMR_UNDER_CH].wrap_down &&
     !st.cap_b[`TMR_PERIOD_CH]) |=> st.general_reg_b[`TMR_PERIOD_CH] == $past(st.shb[0]))
    else $error("complementary reload of primary B at underflow missing");

  a_top_pending: assert property (
    o_irq |-> o_irq_src[o_irq_top])
    else $error("reported top source is not pending");

  a_enable_write: assert property (
    (acc && i_apb.pwrite && (i_apb.paddr == `TMR_OFS_OUTEN) &&
     !(pwm && !st.ctrl.ext_trigger_disable_ctl && cap_a_ev[`TMR_TRIG_CH])) |=>
      o_pin_timer_en == $past(i_apb.pwdata[`TMR_NPIN-1:0]))
    else $error("master enable write not applied");

  a_shadow_hold: assert property (
    ((st.ctrl.buf_en == '0) && !(acc && i_apb.pwrite)) |=>
      $stable(st.sha) && $stable(st.shb))
    else $error("shadow changed without a write or transfer");

endmodule // timer_buffer_output_irq
`default_nettype wire

//--- hw/timer_defs.svh
// offsets, counts and reset values of the buffered capture/compare timer block
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

`define TMR_NCH         5
`define TMR_NSRC        15
`define TMR_SRC_PER_CH  3
`define TMR_SRC_A       0
`define TMR_SRC_B       1
`define TMR_SRC_W       2
`define TMR_CW          16
`define TMR_NPIN        4
`define TMR_NBUF        2
`define TMR_AW          8
`define TMR_DW          32
`define TMR_PRIO1_W     3

`define TMR_BUF_CH0     3
`define TMR_TRIG_CH     1
`define TMR_PERIOD_CH   3
`define TMR_UNDER_CH    4

`define TMR_OFS_CTRL    8'h00
`define TMR_OFS_CAPSEL  8'h04
`define TMR_OFS_OUTEN   8'h08
`define TMR_OFS_STATUS  8'h0c
`define TMR_OFS_IEN     8'h10
`define TMR_OFS_PRIO1   8'h14
`define TMR_OFS_PRIO2   8'h18
`define TMR_OFS_GR_BASE 8'h20
`define TMR_GR_STRIDE   8'h08
`define TMR_OFS_GRB     8'h04
`define TMR_OFS_SH_BASE 8'h48
`define TMR_SH_STRIDE   8'h04

`define TMR_CNT_ALL1    16'hffff
`define TMR_CNT_ZERO    16'h0000
`define TMR_OE_RST      4'hf

`endif

//--- hw/timer_pkg.sv
// types shared by the buffered capture/compare timer block
`include "timer_defs.svh"

package timer_pkg;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_RSYNC, MODE_COMP, MODE_RSVD} pwm_mode_t;

  typedef struct packed {
    logic                level_select_secondary;
    logic                level_select_primary;
    logic                ext_trigger_disable_ctl;
    logic [`TMR_NPIN-1:0] buf_en;
    pwm_mode_t           mode;
  } ctrl_t;

  typedef struct packed {
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [`TMR_AW-1:0]   paddr;
    logic [`TMR_DW-1:0]   pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [`TMR_CW-1:0] cnt;
    logic               tick;
    logic               down;
    logic               cap_a;
    logic               cap_b;
  } chan_in_t;

  typedef struct packed {
    logic match_a;
    logic match_b;
    logic wrap_up;
    logic wrap_down;
  } chan_ev_t;

  typedef struct packed {
    ctrl_t                                ctrl;
    logic [`TMR_NCH-1:0]                  cap_a;
    logic [`TMR_NCH-1:0]                  cap_b;
    logic [`TMR_NPIN-1:0]                 oe;
    logic [`TMR_NSRC-1:0]                 flags;
    logic [`TMR_NSRC-1:0]                 armed;
    logic [`TMR_NSRC-1:0]                 ien;
    logic [`TMR_NCH-1:0]                  prio;
    logic [`TMR_NCH-1:0][`TMR_CW-1:0]     general_reg_a;
    logic [`TMR_NCH-1:0][`TMR_CW-1:0]     general_reg_b;
    logic [`TMR_NBUF-1:0][`TMR_CW-1:0]    sha;
    logic [`TMR_NBUF-1:0][`TMR_CW-1:0]    shb;
    logic [`TMR_NPIN-1:0]                 pin;
    logic [`TMR_DW-1:0]                   rdata;
  } state_t;

endpackage

//--- hw/timer_chan_event.sv
// per-channel compare match and wrap event detection
`timescale 1ns/100ps
`default_nettype none
`include "timer_defs.svh"

module timer_chan_event
  import timer_pkg::*;
(
  input  wire chan_in_t          i_chan,
  input  wire logic [`TMR_CW-1:0] i_gra,
  input  wire logic [`TMR_CW-1:0] i_grb,
  input  wire logic              i_cap_sel_a,
  input  wire logic              i_cap_sel_b,
  output var  chan_ev_t          o_ev
);

  // match fires as the counter leaves the matching count, on the tick taken while the count equals the register
  assign o_ev.match_a = i_chan.tick && !i_cap_sel_a && (i_chan.cnt == i_gra);
  assign o_ev.match_b = i_chan.tick && !i_cap_sel_b && (i_chan.cnt == i_grb);

  assign o_ev.wrap_up   = i_chan.tick && !i_chan.down && (i_chan.cnt == `TMR_CNT_ALL1);
  assign o_ev.wrap_down = i_chan.tick && i_chan.down && (i_chan.cnt == `TMR_CNT_ZERO);

endmodule // timer_chan_event
`default_nettype wire

//--- verif/timer_far_side.sv
// pin fallback to port logic and interrupt controller beside the timer block
`timescale 1ns/100ps
`default_nettype none
`include "timer_defs.svh"

module timer_far_side (
  input  wire logic                 i_clk,
  input  wire logic [`TMR_NPIN-1:0] i_pin_level,
  input  wire logic [`TMR_NPIN-1:0] i_pin_timer_en,
  input  wire logic [`TMR_NPIN-1:0] i_port_value,
  input  wire logic                 i_irq,
  input  wire logic [3:0]           i_irq_top,
  output logic      [`TMR_NPIN-1:0] o_pin,
  output logic      [3:0]           o_vec
);
  // a disabled timer pin shows the port data value instead
  assign o_pin = (i_pin_level & i_pin_timer_en) | (i_port_value & ~i_pin_timer_en);

  // vector is only taken while a request stands; stale otherwise, like a real controller
  always_ff @(posedge i_clk) begin
    if (i_irq) begin
      o_vec <= i_irq_top;
    end
  end
endmodule // timer_far_side

`default_nettype wire

//--- verif/timer_buffer_output_irq_tb.sv
// self-checking bench for the timer buffer, output and interrupt block
`timescale 1ns/100ps
`default_nettype none
`include "timer_defs.svh"

module timer_buffer_output_irq_tb
  import timer_pkg::*;
;
  localparam logic [7:0] a3_reg = 8'h38, b3_reg = 8'h3c, a4_reg = 8'h40, b4_reg = 8'h44;
  localparam logic [7:0] a3_sh = 8'h48, b3_sh = 8'h4c, a4_sh = 8'h50;
  localparam logic [7:0] st = `TMR_OFS_STATUS;

  logic                      clk;
  logic                      rstn;
  apb_req_t                  apb;
  chan_in_t [`TMR_NCH-1:0]   chan;
  logic [31:0]               prdata;
  logic [31:0]               rv;
  logic                      pready;
  logic                      pslverr;
  logic                      ev_err;
  logic                      irq;
  logic [3:0]                pin_level;
  logic [3:0]                pin_en;
  logic [3:0]                port_value_reg;
  logic [3:0]                pin;
  logic [3:0]                vec;
  logic [3:0]                irq_top;
  logic [14:0]               irq_src;
  int                        miscompares = 0;
  int                        n_compared = 0;

  timer_buffer_output_irq u_timer_buffer_output_irq (
    .i_clk(clk), .i_rstn(rstn), .i_apb(apb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_chan(chan), .o_pin_level(pin_level), .o_pin_timer_en(pin_en),
    .o_irq_src(irq_src), .o_irq(irq), .o_irq_top(irq_top));

  timer_far_side u_timer_far_side (
    .i_clk(clk), .i_pin_level(pin_level), .i_pin_timer_en(pin_en),
    .i_port_value(port_value_reg), .i_irq(irq), .i_irq_top(irq_top), .o_pin(pin), .o_vec(vec));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high at an edge, then released
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    apb.penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rv = prdata;
    ev_err = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic chkrd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rv, e);
  endtask

  task automatic idle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // one-cycle event on a channel; results land one cycle after the event edge
  task automatic ev(input int ch, input logic [15:0] c, input logic t, dn, ca);
    @(posedge clk);
    chan[ch] <= '{cnt: c, tick: t, down: dn, cap_a: ca, cap_b: 1'b0};
    @(posedge clk);
    chan[ch].tick <= 1'b0;
    chan[ch].cap_a <= 1'b0;
    idle;
  endtask

  // read arms the set flags, the zero write then clears them
  task automatic clr;
    bus(1'b0, st, 32'h0);
    wr(st, 32'h0);
  endtask

  task automatic t_reset;
    chk(pin_en, 4'hf);
    chkrd(`TMR_OFS_OUTEN, 32'hf);
    chk(irq, 1'b0);
    wr(8'h58, 32'h1234);
    chkrd(8'h58, 32'h0);
    chk(ev_err, 1'b1);
    $display("test done: reset");
  endtask

  task automatic t_cmp;
    wr(`TMR_OFS_IEN, 32'h7fff);
    wr(`TMR_OFS_CTRL, 32'h4);
    wr(a3_reg, 32'h10);
    wr(a3_sh, 32'h55);
    chkrd(a3_sh, 32'h55);
    chkrd(a3_reg, 32'h10);
    ev(3, 16'h10, 1'b0, 1'b0, 1'b0);
    chk(irq_src, 32'h0);
    chkrd(a3_reg, 32'h10);
    ev(3, 16'h10, 1'b1, 1'b0, 1'b0);
    chk(irq_src, 32'h200);
    chk(pin_level[0], 1'b1);
    chkrd(a3_reg, 32'h55);
    wr(a3_sh, 32'h66);
    ev(3, 16'h55, 1'b1, 1'b0, 1'b0);
    chk(pin_level[0], 1'b0);
    chkrd(a3_reg, 32'h66);
    $display("test done: compare buffer");
  endtask

  task automatic t_flags;
    // keep channel one's compares away from zero so only the wrap fires
    wr(8'h28, 32'h100);
    wr(8'h2c, 32'h100);
    ev(0, 16'hffff, 1'b1, 1'b0, 1'b0);
    ev(1, 16'h0, 1'b1, 1'b1, 1'b0);
    wr(st, 32'h0);
    chkrd(st, 32'h224);
    chk(irq_src, 32'h224);
    chk(irq_top, 4'h2);
    wr(st, 32'h4);
    chkrd(st, 32'h4);
    wr(`TMR_OFS_IEN, 32'h7ffb);
    idle;
    chk(irq, 1'b0);
    wr(`TMR_OFS_IEN, 32'h7fff);
    ev(4, 16'hffff, 1'b1, 1'b0, 1'b0);
    chk(irq_top, 4'h2);
    wr(`TMR_OFS_PRIO2, 32'h2);
    idle;
    chk(irq_top, 4'he);
    chk(vec, 4'he);
    wr(`TMR_OFS_PRIO2, 32'h0);
    clr;
    chkrd(st, 32'h0);
    chk(irq, 1'b0);
    $display("test done: flags and requests");
  endtask

  task automatic t_cap;
    wr(`TMR_OFS_CAPSEL, 32'h10);
    wr(`TMR_OFS_CTRL, 32'h10);
    wr(a4_reg, 32'h777);
    ev(4, 16'h1234, 1'b0, 1'b0, 1'b1);
    chk(irq_src, 32'h1000);
    chkrd(a4_reg, 32'h1234);
    chkrd(a4_sh, 32'h777);
    wr(`TMR_OFS_CAPSEL, 32'h0);
    clr;
    $display("test done: capture buffer");
  endtask

  task automatic t_pwm;
    wr(b4_reg, 32'h5000);
    wr(b3_sh, 32'h99);
    wr(`TMR_OFS_CTRL, 32'h89);
    ev(3, 16'h66, 1'b1, 1'b0, 1'b0);
    chk(pin_level[0], 1'b1);
    chkrd(b3_reg, 32'h99);
    wr(`TMR_OFS_CTRL, 32'h09);
    idle;
    chk(pin_level[0], 1'b0);
    clr;
    wr(b3_sh, 32'haa);
    wr(8'h54, 32'h6000);
    wr(`TMR_OFS_CTRL, 32'haa);
    ev(3, 16'h66, 1'b1, 1'b1, 1'b0);
    chk(irq_src, 32'h0);
    chkrd(b3_reg, 32'h99);
    ev(3, 16'h66, 1'b1, 1'b0, 1'b0);
    chk(irq_src, 32'h200);
    chkrd(b3_reg, 32'haa);
    wr(b3_sh, 32'hbb);
    ev(4, 16'hffff, 1'b1, 1'b0, 1'b0);
    chk(irq_src, 32'h200);
    ev(4, 16'h0, 1'b1, 1'b1, 1'b0);
    chk(irq_src, 32'h4200);
    chkrd(b3_reg, 32'hbb);
    chkrd(b4_reg, 32'h6000);
    $display("test done: pwm modes");
  endtask

  task automatic t_outen;
    wr(`TMR_OFS_OUTEN, 32'h5);
    idle;
    chk(pin_en, 4'h5);
    chk({pin[3], pin[1]}, 2'b11);
    wr(`TMR_OFS_CAPSEL, 32'h2);
    ev(1, 16'h0, 1'b0, 1'b0, 1'b1);
    chk(pin_en, 4'h0);
    chkrd(`TMR_OFS_OUTEN, 32'h0);
    wr(`TMR_OFS_OUTEN, 32'hf);
    wr(`TMR_OFS_CTRL, 32'hca);
    ev(1, 16'h0, 1'b0, 1'b0, 1'b1);
    chk(pin_en, 4'hf);
    $display("test done: output enables");
  endtask

  // whole run is a few hundred cycles; this limit leaves ample margin
  initial begin
    #20000;
    miscompares++;
    complete_run;
  end

  initial begin
    rstn = 1'b0;
    apb = '0;
    chan = '0;
    port_value_reg = 4'ha;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset;
    t_cmp;
    t_flags;
    t_cap;
    t_pwm;
    t_outen;
    complete_run;
  end
endmodule // timer_buffer_output_irq_tb

`default_nettype wire
